// >>> lvr_pkg.sv
// Purpose: Shared constants and types for the supply-dip and watchdog reset control
// Assumes: 10 MHz core_clk, AXI4-Lite register access with 32-bit data
// Notes: Times are kept in their own units; cycle counts are derived from them
package lvr_pkg;
	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int DIP_QUALIFY_US = 120;
	localparam int CORRUPT_RESET_DELAY_US = 50;
	localparam int RESET_RELEASE_DELAY_MS = 48;
	localparam int DIP_QUALIFY_CYCLES =
		(DIP_QUALIFY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CORRUPT_RESET_CYCLES =
		(CORRUPT_RESET_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESET_RELEASE_CYCLES =
		(RESET_RELEASE_DELAY_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 12;
	localparam int HOLD_W = 20;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_TRIP = 8'h00;
	localparam logic [7:0] ADDR_CTRL = 8'h04;
	localparam logic [7:0] ADDR_RSTF = 8'h08;
	localparam logic [7:0] ADDR_IRQ = 8'h0c;
	localparam logic [7:0] ADDR_MASK = 8'h10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------
	// Trip codes and field layout
	// ----------------------------------------
	localparam logic [7:0] TRIP_2V10 = 8'h55;
	localparam logic [7:0] TRIP_2V55 = 8'h33;
	localparam logic [7:0] TRIP_3V15 = 8'h99;
	localparam logic [7:0] TRIP_3V80 = 8'haa;
	localparam logic [7:0] TRIP_RESET = TRIP_2V10;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_WMASK = 8'hbf;
	localparam int CTRL_WDT_CORRUPT = 0;
	localparam int CTRL_TRIP_CORRUPT = 1;
	localparam int CTRL_DIP = 2;
	localparam int CTRL_UNUSED = 6;
	localparam int RSTF_POWERDOWN = 3;
	localparam int RSTF_TIMEOUT = 4;
	localparam int IRQ_DIP = 0;
	localparam int IRQ_TRIP = 1;
	localparam int IRQ_WDT = 2;
	localparam int IRQ_WCTRL = 3;
	localparam int IRQ_W = 4;

	typedef enum logic [1:0] {LVR_FAST, LVR_SLOW, LVR_IDLE, LVR_SLEEP} lvr_mode_t;
endpackage

// >>> lvr_qual_if.sv
// Purpose: Link between reset control and the dip qualifier
// Assumes: Single core_clk domain
// Notes: Level in, one-cycle pulse out
`timescale 1ns/1ps
interface lvr_qual_if;
	logic lowSupply;
	logic enable;
	logic qualified;
	modport ctrl (output lowSupply, output enable, input qualified);
	modport qual (input lowSupply, input enable, output qualified);
endinterface

// >>> lvr_dip_qualify.sv
// Purpose: Qualifies the synchronised low-supply level against a minimum time
// Assumes: Free-running core_clk, synchronised input
// Notes: One pulse per qualified dip
`timescale 1ns/1ps
module lvr_dip_qualify
	import lvr_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	lvr_qual_if.qual q
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic done;
		logic pulse;
	} lvr_qual_t;

	lvr_qual_t s;
	lvr_qual_t n;
	localparam logic [CNT_W-1:0] QUAL_LAST = CNT_W'(DIP_QUALIFY_CYCLES);

	// ----------------------------------------
	// Counter
	// ----------------------------------------
	always_comb begin
		n = s;
		n.pulse = 1'b0;
		// (R16) restart on release
		if (!q.lowSupply || !q.enable) begin
			n.cnt = '0;
			n.done = 1'b0;
		end else if (!s.done) begin
			// (R3) longer than qualify time
			if (s.cnt == QUAL_LAST) begin
				n.pulse = 1'b1;
				n.done = 1'b1;
			end else begin
				n.cnt = s.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign q.qualified = s.pulse;

	property p_restart;
		@(posedge core_clk) disable iff (!rstn)
		!q.lowSupply |=> s.cnt == '0 && !s.pulse;
	endproperty
	a_restart: assert property (p_restart) else $error("dip count not restarted"); // (R16)

	property p_qual_time;
		@(posedge core_clk) disable iff (!rstn)
		$rose(s.pulse) |-> $past(q.lowSupply, 1) && s.cnt == QUAL_LAST;
	endproperty
	a_qual_time: assert property (p_qual_time) else $error("dip qualified early"); // (R3)
endmodule

// >>> lvr_reset_ctrl.sv
// Purpose: Supply-dip, trip-code and watchdog reset control with register access
// Assumes: Watchdog counter and analog comparator sit outside this block
// Notes: coreReset holds the core for the release delay after any full reset
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Overview of operation
// (R1) Dip monitor enabled in fast and slow modes, off in sleep or idle.
// (R2) Qualified dip resets the core and sets the supply-dip flag.
// (R3) A dip shorter than the qualify time is ignored entirely.
// (R4) Only four trip codes are valid: 55, 33, 99, aa hex.
// (R5) Invalid trip code: reset after delay, set corrupt flag, restore 55 hex.
// (R6) Supply-dip flag at bit 2 set by hardware, cleared only by software.
// (R7) Trip-corrupt flag at bit 1 set on bad code, cleared only by software.
// (R8) Control bit 6 is unimplemented and reads zero.
// (R9) Run-mode watchdog timeout acts as dip reset and sets timeout flag.
// (R10) Low-power watchdog timeout clears only program counter and stack pointer.
// (R11) Power-on clears both flags; dip keeps; run timeout sets one; low-power both.
// (R12) Power-on holds core reset so program counter, ports, timers initialise.
// (R13) Pointer registers clear on full resets, kept on low-power timeout.
// (R14) Core stays reset for the release delay after a full reset.
// (R15) Watchdog timeout and control-register corruption are reset sources.
// (R16) Dip qualified by a counter that restarts when the dip ends.
module lvr_reset_ctrl
	import lvr_pkg::*;
#(
	parameter int RELEASE_CYCLES = lvr_pkg::RESET_RELEASE_CYCLES
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire lvr_pkg::lvr_mode_t powerMode,
	input wire logic lowSupplyPin,
	input wire logic wdtTimeout,
	input wire logic wdtCtrlCorrupt,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic coreReset,
	output logic pcSpClear,
	output logic ptrClear,
	output logic dipMonitorEn,
	output logic irq
);
	typedef struct packed {
		logic syncA, syncB;
		logic awHave;
		logic [7:0] awAddr;
		logic wHave;
		logic [7:0] wData;
		logic wLane;
		logic awReady, wReady, bValid;
		logic [1:0] bResp;
		logic arReady;
		logic rValid;
		logic [31:0] rData;
		logic [1:0] rResp;
		logic [7:0] trip;
		logic [7:0] ctrl;
		logic timeoutFlag, powerdownFlag;
		logic [IRQ_W-1:0] irqStat;
		logic [IRQ_W-1:0] irqMask;
		logic irq;
		logic [CNT_W-1:0] corruptCnt;
		logic [HOLD_W-1:0] holdCnt;
		logic coreReset;
		logic pcSpClear;
		logic ptrClear;
		logic monEn;
	} lvr_state_t;

	localparam logic [CNT_W-1:0] CORRUPT_LAST = CNT_W'(CORRUPT_RESET_CYCLES);
	localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(RELEASE_CYCLES);

	lvr_state_t s, n;
	logic rstnA, rstn;
	logic lowPower, tripBad, dipReset, fullReset, corruptFire;
	logic wdtRun, wdtSleep, doWrite, doRead;
	logic [IRQ_W-1:0] irqSet, irqClr;
	lvr_qual_if qIf();

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic tripValid(input logic [7:0] code);
		return code == TRIP_2V10 || code == TRIP_2V55 ||
			code == TRIP_3V15 || code == TRIP_3V80;
	endfunction

	function automatic logic mapped(input logic [7:0] addr);
		return addr == ADDR_TRIP || addr == ADDR_CTRL || addr == ADDR_RSTF ||
			addr == ADDR_IRQ || addr == ADDR_MASK;
	endfunction

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rstnA <= 1'b0;
			rstn <= 1'b0;
		end else begin
			rstnA <= 1'b1;
			rstn <= rstnA;
		end
	end

	// ----------------------------------------
	// Dip qualifier
	// ----------------------------------------
	assign qIf.lowSupply = s.syncB;
	assign qIf.enable = s.monEn;

	lvr_dip_qualify u_lvr_dip_qualify (
		.core_clk(core_clk),
		.rstn(rstn),
		.q(qIf.ctrl)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		n = s;
		lowPower = powerMode == LVR_IDLE || powerMode == LVR_SLEEP;
		n.syncA = lowSupplyPin;
		n.syncB = s.syncA;
		// (R1) monitor follows mode
		n.monEn = !lowPower;
		// (R2) qualified dip resets
		dipReset = qIf.qualified && s.monEn;
		// (R4) trip code check
		tripBad = !tripValid(s.trip);
		corruptFire = tripBad && s.corruptCnt == CORRUPT_LAST;
		// (R15) watchdog reset sources
		wdtRun = wdtTimeout && !lowPower;
		wdtSleep = wdtTimeout && lowPower;
		fullReset = dipReset || corruptFire || wdtRun || wdtCtrlCorrupt;
		doWrite = s.awHave && s.wHave && !s.bValid;
		doRead = s_axi_arvalid && s.arReady;
		irqSet = '0;
		irqClr = '0;
		n.pcSpClear = 1'b0;
		n.ptrClear = 1'b0;

		// (R5) delayed corrupt reset
		if (!tripBad || corruptFire) begin
			n.corruptCnt = '0;
		end else begin
			n.corruptCnt = s.corruptCnt + 1'b1;
		end

		// Register writes
		if (doWrite && s.wLane) begin
			case (s.awAddr)
				ADDR_TRIP: n.trip = s.wData;
				// (R6) software clears flags
				ADDR_CTRL: n.ctrl = (s.wData & CTRL_WMASK) | (s.ctrl & ~CTRL_WMASK);
				ADDR_IRQ: irqClr = s.wData[IRQ_W-1:0];
				ADDR_MASK: n.irqMask = s.wData[IRQ_W-1:0];
				default: n.irqMask = s.irqMask;
			endcase
		end

		// (R6) dip flag set wins
		if (dipReset || wdtRun) begin
			n.ctrl[CTRL_DIP] = 1'b1;
			irqSet[IRQ_DIP] = dipReset;
		end
		// (R7) corrupt flag set wins
		if (corruptFire) begin
			n.ctrl[CTRL_TRIP_CORRUPT] = 1'b1;
			n.trip = TRIP_RESET;
			irqSet[IRQ_TRIP] = 1'b1;
		end
		if (wdtCtrlCorrupt) begin
			n.ctrl[CTRL_WDT_CORRUPT] = 1'b1;
			irqSet[IRQ_WCTRL] = 1'b1;
		end
		// (R8) bit 6 stays zero
		n.ctrl[CTRL_UNUSED] = 1'b0;

		// (R9) run timeout flag
		if (wdtRun) begin
			n.timeoutFlag = 1'b1;
			irqSet[IRQ_WDT] = 1'b1;
		end
		// (R10) low-power timeout
		if (wdtSleep) begin
			n.timeoutFlag = 1'b1;
			n.powerdownFlag = 1'b1;
			n.pcSpClear = 1'b1;
			irqSet[IRQ_WDT] = 1'b1;
		end

		// (R14) hold core reset
		if (fullReset) begin
			n.coreReset = 1'b1;
			n.holdCnt = HOLD_LOAD;
			// (R13) pointers cleared
			n.ptrClear = 1'b1;
		end else if (s.holdCnt != '0) begin
			n.holdCnt = s.holdCnt - 1'b1;
		end else begin
			n.coreReset = 1'b0;
		end

		// Interrupt status, set beats clear
		n.irqStat = (s.irqStat & ~irqClr) | irqSet;
		n.irq = |(n.irqStat & n.irqMask);

		// Write channel
		if (s_axi_awvalid && s.awReady) begin
			n.awHave = 1'b1;
			n.awAddr = s_axi_awaddr[7:0];
		end
		if (s_axi_wvalid && s.wReady) begin
			n.wHave = 1'b1;
			n.wData = s_axi_wdata[7:0];
			n.wLane = s_axi_wstrb[0];
		end
		if (doWrite) begin
			n.awHave = 1'b0;
			n.wHave = 1'b0;
			n.bValid = 1'b1;
			n.bResp = mapped(s.awAddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s.bValid && s_axi_bready) begin
			n.bValid = 1'b0;
		end
		n.awReady = !n.awHave && !n.bValid;
		n.wReady = !n.wHave && !n.bValid;

		// Read channel
		if (doRead) begin
			n.rValid = 1'b1;
			n.rResp = mapped(s_axi_araddr[7:0]) ? RESP_OKAY : RESP_SLVERR;
			case (s_axi_araddr[7:0])
				ADDR_TRIP: n.rData = {24'h000000, s.trip};
				ADDR_CTRL: n.rData = {24'h000000, s.ctrl};
				// (R11) reset flags readback
				ADDR_RSTF: n.rData = (32'(s.timeoutFlag) << RSTF_TIMEOUT) |
					(32'(s.powerdownFlag) << RSTF_POWERDOWN);
				ADDR_IRQ: n.rData = {28'h0000000, s.irqStat};
				ADDR_MASK: n.rData = {28'h0000000, s.irqMask};
				default: n.rData = 32'h00000000;
			endcase
		end else if (s.rValid && s_axi_rready) begin
			n.rValid = 1'b0;
		end
		n.arReady = !n.rValid;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
			s.trip <= TRIP_RESET;
			s.ctrl <= CTRL_RESET;
			// (R12) power-on holds core
			s.coreReset <= 1'b1;
			s.holdCnt <= HOLD_LOAD;
			s.ptrClear <= 1'b1;
			s.monEn <= 1'b1;
		end else begin
			s <= n;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign s_axi_awready = s.awReady;
	assign s_axi_wready = s.wReady;
	assign s_axi_bvalid = s.bValid;
	assign s_axi_bresp = s.bResp;
	assign s_axi_arready = s.arReady;
	assign s_axi_rvalid = s.rValid;
	assign s_axi_rdata = s.rData;
	assign s_axi_rresp = s.rResp;
	assign coreReset = s.coreReset;
	assign pcSpClear = s.pcSpClear;
	assign ptrClear = s.ptrClear;
	assign dipMonitorEn = s.monEn;
	assign irq = s.irq;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_mon_off;
		@(posedge core_clk) disable iff (!rstn)
		(powerMode == LVR_IDLE || powerMode == LVR_SLEEP) |=> !dipMonitorEn;
	endproperty
	a_mon_off: assert property (p_mon_off) else $error("monitor on in low power"); // (R1)
	property p_dip_reset;
		@(posedge core_clk) disable iff (!rstn)
		(qIf.qualified && s.monEn) |=> coreReset && s.ctrl[CTRL_DIP] && ptrClear;
	endproperty
	a_dip_reset: assert property (p_dip_reset) else $error("dip did not reset"); // (R2)
	property p_corrupt;
		@(posedge core_clk) disable iff (!rstn)
		(!tripValid(s.trip) && s.corruptCnt == CORRUPT_LAST) |=>
			s.trip == TRIP_RESET && s.ctrl[CTRL_TRIP_CORRUPT] && coreReset;
	endproperty
	a_corrupt: assert property (p_corrupt) else $error("bad trip code not handled"); // (R5)
	property p_good_code;
		@(posedge core_clk) disable iff (!rstn)
		tripValid(s.trip) |=> s.corruptCnt == '0;
	endproperty
	a_good_code: assert property (p_good_code) else $error("valid code counted"); // (R4)
	property p_dip_sticky;
		@(posedge core_clk) disable iff (!rstn)
		$fell(s.ctrl[CTRL_DIP]) |-> $past(doWrite) && $past(s.awAddr) == ADDR_CTRL;
	endproperty
	a_dip_sticky: assert property (p_dip_sticky) else $error("dip flag cleared by hw"); // (R6)
	property p_trip_sticky;
		@(posedge core_clk) disable iff (!rstn)
		$fell(s.ctrl[CTRL_TRIP_CORRUPT]) |-> $past(doWrite) && $past(s.awAddr) == ADDR_CTRL;
	endproperty
	a_trip_sticky: assert property (p_trip_sticky) else $error("corrupt flag cleared"); // (R7)
	property p_bit6;
		@(posedge core_clk) disable iff (!rstn)
		(s_axi_rvalid && $past(doRead) && $past(s_axi_araddr[7:0]) == ADDR_CTRL) |->
			s_axi_rdata[CTRL_UNUSED] == 1'b0;
	endproperty
	a_bit6: assert property (p_bit6) else $error("bit 6 read nonzero"); // (R8)
	property p_wdt_run;
		@(posedge core_clk) disable iff (!rstn)
		(wdtTimeout && !(powerMode == LVR_IDLE || powerMode == LVR_SLEEP)) |=>
			s.timeoutFlag && coreReset && $stable(s.powerdownFlag);
	endproperty
	a_wdt_run: assert property (p_wdt_run) else $error("run timeout wrong"); // (R9)
	sequence s_sleep_to;
		wdtTimeout && (powerMode == LVR_IDLE || powerMode == LVR_SLEEP) && !fullReset;
	endsequence
	sequence s_sleep_fx;
		pcSpClear && !ptrClear && s.timeoutFlag && s.powerdownFlag;
	endsequence
	property p_wdt_sleep;
		@(posedge core_clk) disable iff (!rstn)
		s_sleep_to |=> s_sleep_fx;
	endproperty
	a_wdt_sleep: assert property (p_wdt_sleep) else $error("sleep timeout wrong"); // (R10)
	sequence s_hold_start;
		fullReset ##1 coreReset;
	endsequence
	property p_hold;
		@(posedge core_clk) disable iff (!rstn)
		s_hold_start |-> coreReset[*8];
	endproperty
	a_hold: assert property (p_hold) else $error("core released too early"); // (R14)
endmodule

// >>> lvr_reset_ctrl_tb.sv
// Purpose: Self-checking bench for lvr_reset_ctrl
// Assumes: Bench is the AXI4-Lite master and drives the reset event inputs
// Notes: Fixed expected register values, small release count
`timescale 1ns/1ps
module lvr_reset_ctrl_tb;
	import lvr_pkg::*;
	localparam int RC = 20;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	lvr_mode_t powerMode = LVR_FAST;
	logic lowSupplyPin = 1'b0;
	logic wdtTimeout = 1'b0;
	logic wdtCtrlCorrupt = 1'b0;
	logic [31:0] awaddr = 32'h0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] araddr = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, rsp;
	logic [31:0] rdata, rd;
	logic coreReset, pcSpClear, ptrClear, dipMonitorEn, irq;
	logic prevRst = 1'b0;
	logic [7:0] code;
	logic [7:0] codes [4] = '{TRIP_2V55, TRIP_3V15, TRIP_3V80, TRIP_2V10};
	int errors = 0;
	int checks_done = 0;
	int cycles = 0;
	int ptrCnt = 0;
	int pcSpCnt = 0;
	int rstRise = 0;
	int p0, s0, r0, n;

	lvr_reset_ctrl #(.RELEASE_CYCLES(RC)) u_lvr_reset_ctrl (
		.core_clk(core_clk), .resetn(resetn), .powerMode(powerMode),
		.lowSupplyPin(lowSupplyPin), .wdtTimeout(wdtTimeout), .wdtCtrlCorrupt(wdtCtrlCorrupt),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.coreReset(coreReset), .pcSpClear(pcSpClear), .ptrClear(ptrClear),
		.dipMonitorEn(dipMonitorEn), .irq(irq)
	);

	// ----------------------------------------
	// Clock, monitors and timeout
	// ----------------------------------------
	always #50 core_clk = ~core_clk;

	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		prevRst <= coreReset;
		if (ptrClear === 1'b1) ptrCnt <= ptrCnt + 1;
		if (pcSpClear === 1'b1) pcSpCnt <= pcSpCnt + 1;
		if (coreReset === 1'b1 && prevRst === 1'b0) rstRise <= rstRise + 1;
		if (cycles == 20000) begin
			$display("[ERR] %0t timeout", $time);
			errors = errors + 1;
			give_verdict();
		end
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic give_verdict();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		awaddr <= {24'h0, a};
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw && w)) begin
			@(posedge core_clk);
			if (!aw && awready === 1'b1) begin
				aw = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w && wready === 1'b1) begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b1;
		do @(posedge core_clk); while (bvalid !== 1'b1);
		rsp = bresp;
		bready <= 1'b0;
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		araddr <= {24'h0, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge core_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge core_clk);
		rd = rdata;
		rsp = rresp;
		rready <= 1'b0;
		chk(rd, exp, "read data");
		chk({30'h0, rsp}, {30'h0, er}, "read resp");
	endtask

	task automatic wait_rel(input bit timed);
		@(posedge core_clk);
		n = 1;
		while (coreReset !== 1'b0) begin
			@(posedge core_clk);
			n++;
		end
		if (timed) chk(32'(n >= RC && n <= RC + 4), 32'h1, "release time");
	endtask

	task automatic dip(input int len);
		lowSupplyPin <= 1'b1;
		repeat (len) @(posedge core_clk);
		lowSupplyPin <= 1'b0;
		repeat (20) @(posedge core_clk);
	endtask

	task automatic mark();
		p0 = ptrCnt;
		s0 = pcSpCnt;
		r0 = rstRise;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(61110));
		repeat (5) @(posedge core_clk);
		chk({31'h0, coreReset & ptrClear}, 32'h1, "held in reset");
		resetn <= 1'b1;
		wait_rel(1'b0);
		rc(ADDR_TRIP, 32'(TRIP_RESET), RESP_OKAY);
		rc(ADDR_CTRL, 32'h0, RESP_OKAY);
		rc(ADDR_RSTF, 32'h0, RESP_OKAY);
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_TRIP, 32'(codes[i]), 4'hf);
			rc(ADDR_TRIP, 32'(codes[i]), RESP_OKAY);
		end
		wr(ADDR_CTRL, 32'hffffffff, 4'hf);
		chk({30'h0, rsp}, {30'h0, RESP_OKAY}, "mapped write");
		rc(ADDR_CTRL, 32'hbf, RESP_OKAY);
		wr(ADDR_CTRL, 32'h0, 4'hf);
		wr(8'h40, 32'h5a, 4'hf);
		chk({30'h0, rsp}, {30'h0, RESP_SLVERR}, "unmapped write");
		rc(8'h40, 32'h0, RESP_SLVERR);
		wr(ADDR_MASK, 32'h0f, 4'he);
		rc(ADDR_MASK, 32'h0, RESP_OKAY);
		for (int m = 3; m >= 0; m--) begin
			powerMode <= lvr_mode_t'(m);
			repeat (4) @(posedge core_clk);
			chk(32'(dipMonitorEn), (m < 2) ? 32'h1 : 32'h0, "monitor enable");
		end
		mark();
		powerMode <= LVR_SLEEP;
		dip(DIP_QUALIFY_CYCLES + 100);
		powerMode <= LVR_FAST;
		dip(DIP_QUALIFY_CYCLES / 2);
		chk(32'(rstRise - r0), 32'h0, "ignored dips");
		rc(ADDR_CTRL, 32'h0, RESP_OKAY);
		dip(DIP_QUALIFY_CYCLES + 100);
		chk(32'(rstRise - r0), 32'h1, "dip reset");
		chk(32'(ptrCnt - p0), 32'h1, "dip ptr clear");
		rc(ADDR_CTRL, 32'h4, RESP_OKAY);
		rc(ADDR_RSTF, 32'h0, RESP_OKAY);
		rc(ADDR_IRQ, 32'h1, RESP_OKAY);
		chk(32'(irq), 32'h0, "masked irq");
		wr(ADDR_MASK, 32'h1, 4'hf);
		repeat (2) @(posedge core_clk);
		chk(32'(irq), 32'h1, "irq raised");
		wr(ADDR_IRQ, 32'h1, 4'hf);
		repeat (2) @(posedge core_clk);
		chk(32'(irq), 32'h0, "irq cleared");
		wr(ADDR_MASK, 32'h0, 4'hf);
		wr(ADDR_CTRL, 32'h0, 4'hf);
		rc(ADDR_CTRL, 32'h0, RESP_OKAY);
		do code = 8'($urandom); while (code inside {TRIP_2V10, TRIP_2V55, TRIP_3V15, TRIP_3V80});
		mark();
		wr(ADDR_TRIP, 32'(code), 4'hf);
		repeat (CORRUPT_RESET_CYCLES / 2) @(posedge core_clk);
		rc(ADDR_TRIP, 32'(code), RESP_OKAY);
		chk(32'(rstRise - r0), 32'h0, "early corrupt reset");
		repeat (CORRUPT_RESET_CYCLES) @(posedge core_clk);
		chk(32'(rstRise - r0), 32'h1, "corrupt reset");
		rc(ADDR_TRIP, 32'(TRIP_RESET), RESP_OKAY);
		rc(ADDR_CTRL, 32'h2, RESP_OKAY);
		rc(ADDR_IRQ, 32'h2, RESP_OKAY);
		wr(ADDR_CTRL, 32'h0, 4'hf);
		wr(ADDR_IRQ, 32'hf, 4'hf);
		wdtCtrlCorrupt <= 1'b1;
		@(posedge core_clk);
		wdtCtrlCorrupt <= 1'b0;
		wait_rel(1'b1);
		rc(ADDR_CTRL, 32'h1, RESP_OKAY);
		rc(ADDR_IRQ, 32'h8, RESP_OKAY);
		wr(ADDR_CTRL, 32'h0, 4'hf);
		wr(ADDR_IRQ, 32'hf, 4'hf);
		mark();
		wdtTimeout <= 1'b1;
		@(posedge core_clk);
		wdtTimeout <= 1'b0;
		wait_rel(1'b1);
		chk(32'(rstRise - r0), 32'h1, "run timeout reset");
		chk(32'(ptrCnt - p0), 32'h1, "run timeout ptr");
		rc(ADDR_RSTF, 32'h10, RESP_OKAY);
		rc(ADDR_CTRL, 32'h4, RESP_OKAY);
		rc(ADDR_IRQ, 32'h4, RESP_OKAY);
		wr(ADDR_CTRL, 32'h0, 4'hf);
		wr(ADDR_IRQ, 32'hf, 4'hf);
		mark();
		powerMode <= LVR_SLEEP;
		repeat (3) @(posedge core_clk);
		wdtTimeout <= 1'b1;
		@(posedge core_clk);
		wdtTimeout <= 1'b0;
		repeat (5) @(posedge core_clk);
		chk(32'(pcSpCnt - s0), 32'h1, "pc sp clear");
		chk(32'(ptrCnt - p0) + 32'(rstRise - r0), 32'h0, "no full reset");
		chk(32'(coreReset), 32'h0, "core runs");
		rc(ADDR_RSTF, 32'h18, RESP_OKAY);
		rc(ADDR_CTRL, 32'h0, RESP_OKAY);
		powerMode <= LVR_FAST;
		dip(DIP_QUALIFY_CYCLES + 100);
		rc(ADDR_RSTF, 32'h18, RESP_OKAY);
		resetn <= 1'b0;
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		wait_rel(1'b0);
		rc(ADDR_RSTF, 32'h0, RESP_OKAY);
		rc(ADDR_TRIP, 32'(TRIP_RESET), RESP_OKAY);
		give_verdict();
	end
endmodule
